/* dram_power_limiting_cfg.svh */
// Constants for the DRAM power limiting block
`ifndef DRAM_POWER_LIMITING_CFG_SVH
`define DRAM_POWER_LIMITING_CFG_SVH

// ****************************************
// Field widths
// ****************************************
`define LIM_SAMPLE_W 24
`define LIM_QWCNT_W 32
`define LIM_DUR_W 6
`define LIM_SUB_W 16

// ****************************************
// Configuration field selects (write and read port)
// ****************************************
`define SEL_WR_SAMPLE 4'h0
`define SEL_WR_LIMIT 4'h1
`define SEL_WR_DUR 4'h2
`define SEL_WR_SUBLEN 4'h3
`define SEL_WR_BUDGET 4'h4
`define SEL_WR_CTRL 4'h5
`define SEL_RD_BASE 4'h6
`define SEL_RD_LAST 4'hB
`define SEL_LOCK 4'hC
`define SEL_SERR_EN 4'hD
`define FIELD_COUNT 3'h6

// ****************************************
// Field positions and reset values
// ****************************************
`define CTRL_ENABLE_BIT 2
`define LOCK_BIT 0
`define SERR_EN_BIT 0
`define RST_SAMPLE 24'h000000
`define RST_LIMIT 32'h00000000
`define RST_DUR 6'h00
`define RST_SUB 16'h0000

`endif

/* dram_power_limiting_pkg.sv */
// Types shared by the DRAM power limiting block
package dram_power_limiting_pkg;

	// Settings of one limiting function: lengths in clock cycles, limit and budget in Qwords, duration in sample periods
	typedef struct packed
	{
		logic [23:0] sample_len;
		logic [31:0] qw_limit;
		logic [5:0] duration;
		logic [15:0] sub_len;
		logic [15:0] sub_budget;
		logic enable;
	} lim_cfg_t;

	// Regime of one limiting function
	typedef enum logic {MONITOR_S, LIMIT_S} lim_state_t;

endpackage

/* dram_power_limiting.sv */
// DRAM read and write power limiting: configuration, two limiters, arbiter blocks
`include "dram_power_limiting_cfg.svh"

// ****************************************
// One limiting function
// ****************************************
module lim_engine
(
	input wire logic clk_i, // Core clock
	input wire logic rst_i, // Cold reset, synchronous
	input wire dram_power_limiting_pkg::lim_cfg_t cfg_i, // Settings
	input wire logic qw_i, // One Qword of own type completed
	input wire logic hold_i, // Freeze while monitoring
	output logic limiting_o, // In limiting regime
	output logic mask_o, // Budget spent, block own cycles
	output logic enter_o // Pulse: limiting entered
);
	dram_power_limiting_pkg::lim_state_t state_ff;
	logic [`LIM_SAMPLE_W-1:0] win_ff;
	logic [`LIM_QWCNT_W-1:0] qw_ff;
	logic [`LIM_DUR_W-1:0] dur_ff;
	logic [`LIM_SUB_W-1:0] sub_ff;
	logic [`LIM_SUB_W-1:0] budget_ff;
	wire mon = state_ff == dram_power_limiting_pkg::MONITOR_S;
	wire win_end = win_ff == cfg_i.sample_len - 24'h000001;
	wire sub_end = sub_ff == cfg_i.sub_len - 16'h0001;
	wire dur_end = dur_ff == cfg_i.duration - 6'h01;
	wire [`LIM_QWCNT_W:0] qw_sum = {1'b0, qw_ff} + {32'h00000000, qw_i};
	// Saturating accumulation of completed Qwords
	wire [`LIM_QWCNT_W-1:0] nxt_qw = qw_sum[`LIM_QWCNT_W] ? 32'hFFFFFFFF : qw_sum[31:0];
	wire over = qw_sum > {1'b0, cfg_i.qw_limit};
	wire frozen = hold_i && mon;

	// Status and masking decode
	assign limiting_o = !mon;
	assign mask_o = !mon && (budget_ff == 16'h0000);
	assign enter_o = cfg_i.enable && mon && !frozen && win_end && over;

	// Regime sequencing and counters
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !cfg_i.enable)
		begin
			state_ff <= dram_power_limiting_pkg::MONITOR_S;
			win_ff <= `RST_SAMPLE;
			qw_ff <= `RST_LIMIT;
			dur_ff <= `RST_DUR;
			sub_ff <= `RST_SUB;
			budget_ff <= `RST_SUB;
		end
		else if (frozen)
		begin
			win_ff <= win_ff;
		end
		else
		begin
			unique case (state_ff)
				dram_power_limiting_pkg::MONITOR_S:
				begin
					win_ff <= win_end ? `RST_SAMPLE : win_ff + 24'h000001;
					qw_ff <= win_end ? `RST_LIMIT : nxt_qw;
					if (win_end && over)
					begin
						state_ff <= dram_power_limiting_pkg::LIMIT_S;
						dur_ff <= `RST_DUR;
						sub_ff <= `RST_SUB;
						budget_ff <= cfg_i.sub_budget;
					end
				end
				dram_power_limiting_pkg::LIMIT_S:
				begin
					win_ff <= win_end ? `RST_SAMPLE : win_ff + 24'h000001;
					if (win_end)
					begin
						dur_ff <= dur_ff + 6'h01;
					end
					if (win_end && dur_end)
					begin
						state_ff <= dram_power_limiting_pkg::MONITOR_S;
					end
					sub_ff <= sub_end ? `RST_SUB : sub_ff + 16'h0001;
					if (sub_end)
					begin
						budget_ff <= cfg_i.sub_budget;
					end
					else if (qw_i && budget_ff != 16'h0000)
					begin
						budget_ff <= budget_ff - 16'h0001;
					end
				end
			endcase
		end
	end
endmodule

// ****************************************
// Top: configuration store and arbiter blocking
// ****************************************
module dram_power_limiting
(
	input wire logic CLOCK_I, // Core clock, 10 MHz
	input wire logic RESET_I, // Cold reset, synchronous, active high
	input wire logic CFG_WR_I, // Configuration write strobe
	input wire logic [3:0] CFG_SEL_I, // Field select for write and read
	input wire logic [31:0] CFG_WDATA_I, // Configuration write data
	output logic [31:0] CFG_RDATA_O, // Selected field, one cycle later
	input wire logic RD_QW_DONE_I, // One Qword read completed
	input wire logic WR_QW_DONE_I, // One Qword write completed
	input wire logic RD_HITS_POSTED_I, // Read address matches a posted write
	output logic RD_BLOCK_O, // Arbiter must hold reads
	output logic WR_BLOCK_O, // Arbiter must hold writes
	output logic RD_LIMITING_O, // Read function limiting
	output logic WR_LIMITING_O, // Write function limiting
	output logic SERR_O // Pulse when limiting is entered
);
	dram_power_limiting_pkg::lim_cfg_t wr_cfg_ff;
	dram_power_limiting_pkg::lim_cfg_t rd_cfg_ff;
	logic lock_ff;
	logic serr_en_ff;
	logic serr_ff;
	logic [31:0] rdata_ff;
	logic rd_mask;
	logic wr_mask;
	logic rd_enter;
	logic wr_enter;

	// Store one field of a function's settings
	function automatic dram_power_limiting_pkg::lim_cfg_t put_field(
		input dram_power_limiting_pkg::lim_cfg_t c, input logic [2:0] idx,
		input logic [31:0] d);
		dram_power_limiting_pkg::lim_cfg_t r;
		r = c;
		unique case (idx)
			3'h0: r.sample_len = d[23:0];
			3'h1: r.qw_limit = d;
			3'h2: r.duration = d[5:0];
			3'h3: r.sub_len = d[15:0];
			3'h4: r.sub_budget = d[15:0];
			default: r.enable = d[`CTRL_ENABLE_BIT];
		endcase
		return r;
	endfunction

	// Read back one field, unused bits zero
	function automatic logic [31:0] get_field(
		input dram_power_limiting_pkg::lim_cfg_t c, input logic [2:0] idx);
		logic [31:0] r;
		r = 32'h00000000;
		unique case (idx)
			3'h0: r = {8'h00, c.sample_len};
			3'h1: r = c.qw_limit;
			3'h2: r = {26'h0000000, c.duration};
			3'h3: r = {16'h0000, c.sub_len};
			3'h4: r = {16'h0000, c.sub_budget};
			default: r = {29'h00000000, c.enable, 2'h0};
		endcase
		return r;
	endfunction

	// Address decode of the configuration port
	wire sel_wr = CFG_SEL_I < `SEL_RD_BASE;
	wire sel_rd = (CFG_SEL_I >= `SEL_RD_BASE) && (CFG_SEL_I <= `SEL_RD_LAST);
	wire [3:0] rd_off = CFG_SEL_I - `SEL_RD_BASE;
	wire [2:0] wr_idx = CFG_SEL_I[2:0];
	wire [2:0] rd_idx = rd_off[2:0];
	wire cfg_open = CFG_WR_I && !lock_ff;
	wire [31:0] nxt_rdata = sel_wr ? get_field(wr_cfg_ff, wr_idx) :
		sel_rd ? get_field(rd_cfg_ff, rd_idx) :
		(CFG_SEL_I == `SEL_LOCK) ? {31'h00000000, lock_ff} :
		(CFG_SEL_I == `SEL_SERR_EN) ? {31'h00000000, serr_en_ff} : 32'h00000000;

	// Configuration registers
	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
		begin
			wr_cfg_ff <= '0;
			rd_cfg_ff <= '0;
			lock_ff <= 1'b0;
			serr_en_ff <= 1'b0;
		end
		else
		begin
			if (cfg_open && sel_wr)
			begin
				wr_cfg_ff <= put_field(wr_cfg_ff, wr_idx, CFG_WDATA_I);
			end
			if (cfg_open && sel_rd)
			begin
				rd_cfg_ff <= put_field(rd_cfg_ff, rd_idx, CFG_WDATA_I);
			end
			if (cfg_open && CFG_SEL_I == `SEL_LOCK)
			begin
				lock_ff <= CFG_WDATA_I[`LOCK_BIT];
			end
			if (CFG_WR_I && CFG_SEL_I == `SEL_SERR_EN)
			begin
				serr_en_ff <= CFG_WDATA_I[`SERR_EN_BIT];
			end
		end
	end

	// Read data and error pulse
	always_ff @(posedge CLOCK_I)
	begin
		if (RESET_I)
		begin
			rdata_ff <= 32'h00000000;
			serr_ff <= 1'b0;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
			serr_ff <= serr_en_ff && (rd_enter || wr_enter);
		end
	end

	lim_engine wr_engine
	(
		.clk_i(CLOCK_I),
		.rst_i(RESET_I),
		.cfg_i(wr_cfg_ff),
		.qw_i(WR_QW_DONE_I),
		.hold_i(rd_mask),
		.limiting_o(WR_LIMITING_O),
		.mask_o(wr_mask),
		.enter_o(wr_enter)
	);

	lim_engine rd_engine
	(
		.clk_i(CLOCK_I),
		.rst_i(RESET_I),
		.cfg_i(rd_cfg_ff),
		.qw_i(RD_QW_DONE_I),
		.hold_i(1'b0),
		.limiting_o(RD_LIMITING_O),
		.mask_o(rd_mask),
		.enter_o(rd_enter)
	);

	// Arbiter blocking; refresh has no block term here and is never held
	// refresh untouched
	assign RD_BLOCK_O = rd_mask || (wr_mask && RD_HITS_POSTED_I);
	assign WR_BLOCK_O = rd_mask || wr_mask;
	assign CFG_RDATA_O = rdata_ff;
	assign SERR_O = serr_ff;
endmodule

/* power_lim_checker.sv */
// Port assertions for the DRAM power limiting block
module power_lim_checker
(
	input wire logic CLOCK_I, // Core clock
	input wire logic RESET_I, // Reset
	input wire logic CFG_WR_I, // Write strobe
	input wire logic [3:0] CFG_SEL_I, // Field select
	input wire logic [31:0] CFG_RDATA_O, // Readback
	input wire logic RD_HITS_POSTED_I, // Read hits write
	input wire logic RD_BLOCK_O, // Reads held
	input wire logic WR_BLOCK_O, // Writes held
	input wire logic RD_LIMITING_O, // Read limiting
	input wire logic WR_LIMITING_O, // Write limiting
	input wire logic SERR_O // Error pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (RESET_I);
	a_wr_block_src: assert property (WR_BLOCK_O |-> RD_LIMITING_O || WR_LIMITING_O)
		else $error("write block outside limiting");
	a_rd_block_src: assert property (RD_BLOCK_O |-> RD_LIMITING_O ||
		(WR_LIMITING_O && RD_HITS_POSTED_I)) else $error("read block outside limiting");
	a_rd_mask_all: assert property (RD_BLOCK_O && !RD_HITS_POSTED_I |-> WR_BLOCK_O)
		else $error("read mask let writes pass");
	a_wr_mask_free: assert property (WR_BLOCK_O && !RD_LIMITING_O && !RD_HITS_POSTED_I
		|-> !RD_BLOCK_O) else $error("free read held by write mask");
	a_hit_held: assert property (WR_BLOCK_O && RD_HITS_POSTED_I |-> RD_BLOCK_O)
		else $error("read hitting posted write not held");
	// Error pulse follows entry
	// The pulse and the regime flag leave their flops on the same edge
	a_serr_entry: assert property (SERR_O |->
		(RD_LIMITING_O && !$past(RD_LIMITING_O)) || (WR_LIMITING_O && !$past(WR_LIMITING_O)))
		else $error("error pulse without entry");
	a_reset_clear: assert property ($fell(RESET_I) |-> !RD_LIMITING_O && !WR_LIMITING_O
		&& !SERR_O && CFG_RDATA_O == 32'h0) else $error("state not cleared by reset");
	a_read_hold: assert property (!$past(CFG_WR_I) && $stable(CFG_SEL_I)
		|=> $stable(CFG_RDATA_O)) else $error("readback changed without write");
endmodule

/* dram_arb_model.sv */
// Arbiter and requestors beside the limiting block
module dram_arb_model
(
	input wire logic rd_req_i, // Read wanted
	input wire logic wr_req_i, // Write wanted
	input wire logic rd_block_i, // Reads held
	input wire logic wr_block_i, // Writes held
	output logic rd_done_o, // Read Qword done
	output logic wr_done_o // Write Qword done
);
	timeunit 1ns;
	timeprecision 1ns;
	// Held kinds never complete a Qword
	assign rd_done_o = rd_req_i & ~rd_block_i;
	assign wr_done_o = wr_req_i & ~wr_block_i;
endmodule

/* testbench.sv */
// Self-checking bench for the DRAM power limiting block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] MASKS [6] = '{32'h00FFFFFF, 32'hFFFFFFFF, 32'h0000003F,
		32'h0000FFFF, 32'h0000FFFF, 32'h00000004};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cfg_wr = 1'b0;
	logic [3:0] cfg_sel = 4'h0;
	logic [31:0] cfg_wdata = 32'h0;
	logic rd_req = 1'b0;
	logic wr_req = 1'b0;
	logic hits = 1'b0;
	logic [31:0] cfg_rdata;
	logic [31:0] seed = 32'h4D;
	logic [31:0] r;
	logic rd_done, wr_done, rd_block, wr_block, rd_lim, wr_lim, serr;
	int error_cnt = 0;
	int checked = 0;
	int cyc, qw, tot, pulses;

	// Clock of 100 ns period
	always #50 clk = ~clk;

	dram_power_limiting dut_u (.CLOCK_I(clk), .RESET_I(rst), .CFG_WR_I(cfg_wr),
		.CFG_SEL_I(cfg_sel), .CFG_WDATA_I(cfg_wdata), .CFG_RDATA_O(cfg_rdata),
		.RD_QW_DONE_I(rd_done), .WR_QW_DONE_I(wr_done), .RD_HITS_POSTED_I(hits),
		.RD_BLOCK_O(rd_block), .WR_BLOCK_O(wr_block), .RD_LIMITING_O(rd_lim),
		.WR_LIMITING_O(wr_lim), .SERR_O(serr));
	dram_arb_model arb_u (.rd_req_i(rd_req), .wr_req_i(wr_req), .rd_block_i(rd_block),
		.wr_block_i(wr_block), .rd_done_o(rd_done), .wr_done_o(wr_done));

	function automatic logic [31:0] xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Qwords passed in one limiting period under constant demand
	function automatic int exp_qw(input int d, s, l, b);
		return d * s / l * b;
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
	endtask

	task automatic wr_cfg(input logic [3:0] sel, input logic [31:0] data);
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_sel <= sel;
		cfg_wdata <= data;
		@(posedge clk);
		cfg_wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] sel, input logic [31:0] exp);
		@(posedge clk);
		cfg_sel <= sel;
		@(posedge clk);
		@(negedge clk);
		check(cfg_rdata, exp);
	endtask

	// All five fields non-zero, then enable with low bits clear
	task automatic load_func(input logic [3:0] base, input int s, lim, d, l, b);
		wr_cfg(base, s);
		wr_cfg(base + 4'h1, lim);
		wr_cfg(base + 4'h2, d);
		wr_cfg(base + 4'h3, l);
		wr_cfg(base + 4'h4, b);
		wr_cfg(base + 4'h5, 32'h4);
	endtask

	// Demand on one kind, random traffic on the other, until one period ends
	task automatic measure(input logic is_rd, input int span);
		logic lim;
		logic seen;
		int n;
		cyc = 0;
		qw = 0;
		tot = 0;
		pulses = 0;
		seen = 1'b0;
		n = 0;
		while (n < span && !(seen && !lim))
		begin
			r = xorshift();
			@(posedge clk);
			rd_req <= is_rd | r[0];
			wr_req <= !is_rd | r[1];
			hits <= r[2];
			@(negedge clk);
			lim = is_rd ? rd_lim : wr_lim;
			seen = seen | lim;
			cyc += lim;
			qw += lim & (is_rd ? rd_done : wr_done);
			tot += is_rd ? rd_done : wr_done;
			pulses += serr;
			n++;
		end
		@(posedge clk);
		rd_req <= 1'b0;
		wr_req <= 1'b0;
	endtask

	// Watchdog: the whole run needs well under 1000 cycles
	initial
	begin
		repeat (3000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end

	initial
	begin
		do_reset();
		for (int i = 0; i < 16; i++)
			rd_chk(i[3:0], 32'h0);
		$display("test reset values done");
		for (int i = 0; i < 12; i++)
		begin
			r = xorshift();
			r = (i % 6 == 5) ? r & 32'hFFFFFFFC : r;
			wr_cfg(i[3:0], r);
			rd_chk(i[3:0], r & MASKS[i % 6]);
		end
		wr_cfg(4'hE, xorshift());
		rd_chk(4'hE, 32'h0);
		wr_cfg(4'h5, 32'h0);
		wr_cfg(4'hB, 32'h0);
		$display("test field access done");
		wr_cfg(4'hD, 32'h1);
		load_func(4'h0, 8, 1, 2, 4, 2);
		measure(1'b0, 300);
		check(cyc, 16);
		check(qw, exp_qw(2, 8, 4, 2));
		check(pulses, 1);
		wr_cfg(4'h5, 32'h0);
		$display("test write limiting done");
		wr_cfg(4'hD, 32'h0);
		load_func(4'h6, 4, 1, 1, 2, 1);
		measure(1'b1, 300);
		check(cyc, 4);
		check(qw, exp_qw(1, 4, 2, 1));
		check(pulses, 0);
		wr_cfg(4'hB, 32'h0);
		$display("test read limiting done");
		load_func(4'h0, 4, 1000, 1, 2, 1);
		measure(1'b0, 40);
		check(cyc, 0);
		check(tot, 40);
		$display("test below threshold done");
		wr_cfg(4'hC, 32'h1);
		wr_cfg(4'h0, xorshift());
		rd_chk(4'h0, 32'h4);
		rd_chk(4'hC, 32'h1);
		wr_cfg(4'hD, 32'h1);
		rd_chk(4'hD, 32'h1);
		$display("test lock done");
		// Raise reset on a rising edge, not at the falling edge where the read check ended
		@(posedge clk);
		do_reset();
		rd_chk(4'hC, 32'h0);
		rd_chk(4'h0, 32'h0);
		$display("test second reset done");
		end_of_test();
	end
endmodule

bind dram_power_limiting power_lim_checker chk_u (.CLOCK_I, .RESET_I, .CFG_WR_I,
	.CFG_SEL_I, .CFG_RDATA_O, .RD_HITS_POSTED_I, .RD_BLOCK_O, .WR_BLOCK_O,
	.RD_LIMITING_O, .WR_LIMITING_O, .SERR_O);
